// >>> core/dfl_map.svh
// Register offsets, field positions and reset values
`ifndef DFL_MAP_SVH
`define DFL_MAP_SVH
`define DFL_ADDR_W 8
`define DFL_PIX_W 24
`define DFL_OFF_LEN 8'h28
`define DFL_OFF_TALLY 8'h2C
`define DFL_OFF_CTRL 8'h40
`define DFL_LEN_HI 23
`define DFL_LEN_LO 3
`define DFL_DLY_HI 7
`define DFL_DLY_LO 6
`define DFL_HPOL 4
`define DFL_VPOL 3
`define DFL_SEL 0
`define DFL_LEN_RST 21'h000000
`define DFL_TALLY_RST 32'h00000000
`define DFL_DLY_RST 2'h0
`endif

// >>> core/dfl_pkg.sv
// Types shared by the frame length and port 0 control block
`include "dfl_map.svh"
package dfl_pkg;
	typedef struct packed
	{
		logic [1:0] sync_delay;
		logic port0_line_sync_polarity;
		logic port0_frame_sync_polarity;
		logic port0_select;
	} dfl_ctrl_t;

	typedef struct packed
	{
		logic hsync;
		logic vsync;
		logic blank;
		logic [`DFL_PIX_W-1:0] data;
	} dfl_timing_t;

	typedef struct packed
	{
		logic hsync;
		logic vsync;
		logic blank;
		logic clk_en;
		logic [`DFL_PIX_W-1:0] data;
	} dfl_port_t;
endpackage

// >>> core/dfl_top.sv
// Frame length, base change tally and output port 0 control
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "dfl_map.svh"
// What this block does
// - Length bits 23:3 are writable and bits 2:0 read as zero.
// - A new length is accepted anytime but used from the next frame, or from the next clock while stopped.
// - A 32-bit tally counts every change of the active base address, except one that meets a tally write in the same clock or comes while stopped.
// - The tally is cleared while the controller is stopped.
// - Port 0 syncs are delayed 0 to 3 clocks by bits 7:6.
// - Bit 4 set makes port 0 line sync active high, else low.
// - Bit 3 set makes port 0 frame sync active high, else low.
// - Port 0 is enabled only while bit 0 is set; it resets clear.
// - Deselected port 0 shows blank and idle sync, data and clock.
// - A change of the select bit acts at once.
// - A queued base is taken only at frame end, else the last kept.
module dfl_top
	import dfl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [`DFL_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic controller_running_status,
	input wire logic frame_fetch_done,
	input wire logic base_queue_pending,
	output logic [23:0] active_frame_length,
	input wire dfl_timing_t timing_in,
	output dfl_port_t port0_out
);

	// ***********************************
	// Helpers
	// ***********************************
	function automatic logic sync_drive(input logic sel, input logic pol,
		input logic raw);
		sync_drive = sel ? (pol ? raw : !raw) : !pol;
	endfunction

	// ***********************************
	// Register file
	// ***********************************
	logic [20:0] length_upper_field;
	logic [20:0] next_length_upper_field;
	logic [20:0] applied_len;
	logic [20:0] next_applied_len;
	logic [31:0] base_change_tally;
	logic [31:0] next_base_change_tally;
	dfl_ctrl_t ctrl;
	dfl_ctrl_t next_ctrl;
	logic [31:0] next_reg_rdata;
	logic wr_len;
	logic wr_tally;
	logic wr_ctrl;
	logic base_switch;

	assign wr_len = reg_wr && (reg_addr == `DFL_OFF_LEN);
	assign wr_tally = reg_wr && (reg_addr == `DFL_OFF_TALLY);
	assign wr_ctrl = reg_wr && (reg_addr == `DFL_OFF_CTRL);
	assign base_switch = frame_fetch_done && base_queue_pending;

	always_comb
	begin
		next_length_upper_field = length_upper_field;
		next_applied_len = applied_len;
		next_base_change_tally = base_change_tally;
		next_ctrl = ctrl;
		if (wr_len)
			next_length_upper_field =
				reg_wdata[`DFL_LEN_HI:`DFL_LEN_LO];
		if (frame_fetch_done || !controller_running_status)
			next_applied_len = length_upper_field;
		if (!controller_running_status)
			next_base_change_tally = `DFL_TALLY_RST;
		else if (wr_tally)
			next_base_change_tally = reg_wdata;
		else if (base_switch)
			next_base_change_tally = base_change_tally + 32'h00000001;
		if (wr_ctrl)
		begin
			next_ctrl.sync_delay = reg_wdata[`DFL_DLY_HI:`DFL_DLY_LO];
			next_ctrl.port0_line_sync_polarity = reg_wdata[`DFL_HPOL];
			next_ctrl.port0_frame_sync_polarity = reg_wdata[`DFL_VPOL];
			next_ctrl.port0_select = reg_wdata[`DFL_SEL];
		end
		next_reg_rdata = 32'h00000000;
		if (reg_rd)
		begin
			unique case (reg_addr)
				`DFL_OFF_LEN:
					next_reg_rdata = {8'h00, length_upper_field, 3'h0};
				`DFL_OFF_TALLY:
					next_reg_rdata = base_change_tally;
				`DFL_OFF_CTRL:
					next_reg_rdata = {24'h000000, ctrl.sync_delay, 1'b0,
						ctrl.port0_line_sync_polarity,
						ctrl.port0_frame_sync_polarity, 2'h0,
						ctrl.port0_select};
				default:
					next_reg_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			length_upper_field <= `DFL_LEN_RST;
			applied_len <= `DFL_LEN_RST;
			base_change_tally <= `DFL_TALLY_RST;
			ctrl <= '0;
			reg_rdata <= 32'h00000000;
		end
		else
		begin
			length_upper_field <= next_length_upper_field;
			applied_len <= next_applied_len;
			base_change_tally <= next_base_change_tally;
			ctrl <= next_ctrl;
			reg_rdata <= next_reg_rdata;
		end
	end

	assign active_frame_length = {applied_len, 3'h0};

	// ***********************************
	// Port 0 output path
	// ***********************************
	logic [2:0] h_pipe;
	logic [2:0] v_pipe;
	logic [2:0] next_h_pipe;
	logic [2:0] next_v_pipe;
	dfl_port_t next_port0_out;
	logic h_tap;
	logic v_tap;
	logic sel;

	assign sel = ctrl.port0_select;

	always_comb
	begin
		next_h_pipe = {h_pipe[1:0], timing_in.hsync};
		next_v_pipe = {v_pipe[1:0], timing_in.vsync};
		unique case (ctrl.sync_delay)
			2'h0:
			begin
				h_tap = timing_in.hsync;
				v_tap = timing_in.vsync;
			end
			2'h1:
			begin
				h_tap = h_pipe[0];
				v_tap = v_pipe[0];
			end
			2'h2:
			begin
				h_tap = h_pipe[1];
				v_tap = v_pipe[1];
			end
			2'h3:
			begin
				h_tap = h_pipe[2];
				v_tap = v_pipe[2];
			end
		endcase
		next_port0_out.hsync =
			sync_drive(sel, ctrl.port0_line_sync_polarity, h_tap);
		next_port0_out.vsync =
			sync_drive(sel, ctrl.port0_frame_sync_polarity, v_tap);
		next_port0_out.blank = sel ? timing_in.blank : 1'b1;
		next_port0_out.clk_en = sel;
		next_port0_out.data = sel ? timing_in.data : '0;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			h_pipe <= 3'h0;
			v_pipe <= 3'h0;
			port0_out <= {1'b1, 1'b1, 1'b1, 1'b0, 24'h000000};
		end
		else
		begin
			h_pipe <= next_h_pipe;
			v_pipe <= next_v_pipe;
			port0_out <= next_port0_out;
		end
	end

	// ***********************************
	// Assertions
	// ***********************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_fetch_end;
		controller_running_status && base_switch && !wr_tally;
	endsequence

	sequence s_len_read;
		reg_rd && reg_addr == `DFL_OFF_LEN;
	endsequence

	sequence s_len_write;
		wr_len;
	endsequence

	sequence s_ctrl_write;
		wr_ctrl;
	endsequence

	a_len_low_zero: assert property (s_len_read |=>
		reg_rdata[2:0] == 3'h0)
		else $error("length low bits not zero");
	a_len_hold: assert property (controller_running_status &&
		!frame_fetch_done |=> $stable(active_frame_length))
		else $error("length changed mid frame");
	a_len_take: assert property (frame_fetch_done |=>
		active_frame_length[23:3] == $past(length_upper_field))
		else $error("length not taken at frame end");
	a_tally_inc: assert property (s_fetch_end |=>
		base_change_tally == $past(base_change_tally) + 32'h00000001)
		else $error("tally did not count");
	a_tally_clear: assert property (!controller_running_status |=>
		base_change_tally == 32'h00000000)
		else $error("tally not cleared when stopped");
	a_tally_keep: assert property (controller_running_status &&
		!base_switch && !wr_tally |=> $stable(base_change_tally))
		else $error("tally moved without base change");
	a_tally_load: assert property (controller_running_status &&
		wr_tally |=> base_change_tally == $past(reg_wdata))
		else $error("tally write not loaded");
	a_hsync_delay: assert property (sel && ctrl.sync_delay == 2'h2 &&
		ctrl.port0_line_sync_polarity |=>
		port0_out.hsync == $past(timing_in.hsync, 3))
		else $error("line sync delay wrong");
	a_hsync_low: assert property (sel && ctrl.sync_delay == 2'h0 &&
		!ctrl.port0_line_sync_polarity |=>
		port0_out.hsync == !$past(timing_in.hsync))
		else $error("line sync polarity wrong");
	a_vsync_high: assert property (sel && ctrl.sync_delay == 2'h3 &&
		ctrl.port0_frame_sync_polarity |=>
		port0_out.vsync == $past(timing_in.vsync, 4))
		else $error("frame sync delay or polarity wrong");
	a_desel_idle: assert property (!sel |=> port0_out.blank &&
		!port0_out.clk_en && port0_out.data == '0)
		else $error("deselected port not idle");
	a_sel_now: assert property ($rose(sel) |=> port0_out.clk_en)
		else $error("select not immediate");
	a_data_timing: assert property (sel |=>
		port0_out.data == $past(timing_in.data))
		else $error("data timing altered");

	// ***********************************
	// Register store, tally wrap, stopped length and port sync checks
	// ***********************************
	a_len_store: assert property (s_len_write |=>
		length_upper_field == $past(reg_wdata[`DFL_LEN_HI:`DFL_LEN_LO]))
		else $error("length write not stored");
	a_len_readback: assert property (s_len_read |=>
		reg_rdata[`DFL_LEN_HI:`DFL_LEN_LO] == $past(length_upper_field))
		else $error("length readback wrong");
	a_ctrl_store: assert property (s_ctrl_write |=>
		ctrl.port0_select == $past(reg_wdata[`DFL_SEL]) &&
		ctrl.sync_delay == $past(reg_wdata[`DFL_DLY_HI:`DFL_DLY_LO]))
		else $error("port control write not stored");
	a_tally_wrap: assert property (controller_running_status &&
		base_switch && !wr_tally &&
		base_change_tally == 32'hFFFFFFFF |=>
		base_change_tally == 32'h00000000)
		else $error("tally did not wrap");
	a_hsync_one: assert property (sel && ctrl.sync_delay == 2'h1 &&
		ctrl.port0_line_sync_polarity |=>
		port0_out.hsync == $past(timing_in.hsync, 2))
		else $error("line sync one clock delay wrong");
	a_vsync_low: assert property (sel && ctrl.sync_delay == 2'h0 &&
		!ctrl.port0_frame_sync_polarity |=>
		port0_out.vsync == !$past(timing_in.vsync))
		else $error("frame sync polarity wrong");
	a_desel_sync: assert property (!sel |=>
		port0_out.hsync == !$past(ctrl.port0_line_sync_polarity) &&
		port0_out.vsync == !$past(ctrl.port0_frame_sync_polarity))
		else $error("deselected sync not idle");
	a_stop_length: assert property (!controller_running_status |=>
		active_frame_length[23:3] == $past(length_upper_field))
		else $error("length not applied while stopped");
endmodule

// >>> tb/dfl_sink.sv
// Model of the transmitter fed by output port 0
`timescale 1ns/1ps
module dfl_sink
	import dfl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire dfl_port_t port0_in,
	output logic [15:0] pix_cnt
);
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
			pix_cnt <= 16'h0000;
		else if (port0_in.clk_en && !port0_in.blank)
			pix_cnt <= pix_cnt + 16'h0001;
endmodule

// >>> tb/dfl_top_tb.sv
// Self-checking bench for frame length and port 0 control
`timescale 1ns/1ps
`include "dfl_map.svh"
module dfl_top_tb
	import dfl_pkg::*;
;
	logic sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
	logic run = 0, done = 0, pend = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, lf = 32'h0000005D, exq[$];
	logic [23:0] afl;
	logic [15:0] pix;
	dfl_timing_t tim = '0;
	dfl_port_t p0;
	int failures = 0, tests_run = 0, k;
	always #12.5 sys_clk = ~sys_clk;
	dfl_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .controller_running_status(run),
		.frame_fetch_done(done), .base_queue_pending(pend),
		.active_frame_length(afl), .timing_in(tim), .port0_out(p0));
	dfl_sink i_sink (.sys_clk(sys_clk), .rstn(rstn), .port0_in(p0),
		.pix_cnt(pix));
	task automatic check(input string n, input logic [31:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			failures++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exq.push_back(e);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask
	task automatic fetch(input logic p);
		@(posedge sys_clk);
		done <= 1'b1;
		pend <= p;
		@(posedge sys_clk);
		done <= 1'b0;
		#1;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Read data one cycle after the strobe
	always @(posedge sys_clk)
	begin
		if (rd_d)
			check("rdata", reg_rdata, exq.pop_front());
		rd_d <= reg_rd;
	end
	initial
	begin
		#100000;
		failures++;
		stop_test;
	end
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		#1;
		check("idle", {p0.hsync, p0.vsync, p0.blank, p0.clk_en}, 4'hE);
		rd(`DFL_OFF_LEN, 32'h0);
		rd(`DFL_OFF_TALLY, 32'h0);
		rd(`DFL_OFF_CTRL, 32'h0);
		wr(8'h30, 32'hFFFFFFFF);
		rd(8'h30, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 8; i++)
		begin
			logic [31:0] c;
			c = {24'hFFFFFF, i[1:0], 1'b1, i[2], !i[2], 3'b111};
			@(posedge sys_clk);
			tim <= '0;
			@(posedge sys_clk);
			wr(`DFL_OFF_CTRL, c);
			rd(`DFL_OFF_CTRL, c & 32'h000000D9);
			check("hidle", p0.hsync, !c[4]);
			check("vidle", p0.vsync, !c[3]);
			tim.hsync <= 1'b1;
			tim.vsync <= 1'b1;
			tim.data <= lf[23:0];
			k = 0;
			repeat (8)
			begin
				@(posedge sys_clk);
				#1;
				k++;
				if (k == 1)
					check("data", {p0.clk_en, p0.data}, {1'b1, lf[23:0]});
				if (p0.hsync === c[4])
					break;
			end
			check("delay", k, i % 4 + 1);
			check("vsync", p0.vsync, c[3]);
			lf = nx(lf);
		end
		tim.blank <= 1'b0;
		wr(`DFL_OFF_CTRL, 32'h00000010);
		@(posedge sys_clk);
		#1;
		check("desel", {p0.hsync, p0.vsync, p0.blank, p0.clk_en, p0.data},
			28'h6000000);
		k = pix;
		repeat (3) @(posedge sys_clk);
		check("sink", pix, k);
		run <= 1'b1;
		$display("test ctrl done");
		wr(`DFL_OFF_LEN, lf);
		rd(`DFL_OFF_LEN, lf & 32'h00FFFFF8);
		check("hold", afl, 24'h0);
		fetch(1'b0);
		check("len", afl, lf[23:0] & 24'hFFFFF8);
		wr(`DFL_OFF_LEN, 32'h000E1000);
		fetch(1'b0);
		check("len24", afl, 24'h0E1000);
		$display("test len done");
		repeat (3) fetch(1'b1);
		fetch(1'b0);
		rd(`DFL_OFF_TALLY, 32'h3);
		wr(`DFL_OFF_TALLY, 32'hFFFFFFFF);
		fetch(1'b1);
		rd(`DFL_OFF_TALLY, 32'h0);
		fetch(1'b1);
		rd(`DFL_OFF_TALLY, 32'h1);
		run <= 1'b0;
		rd(`DFL_OFF_TALLY, 32'h0);
		$display("test tally done");
		repeat (2) @(posedge sys_clk);
		stop_test;
	end
endmodule
